// [rtl/flbec_pkg.sv]
// Package with the constants and types of the flash bank erase control.
package flbec_pkg;

  localparam int unsigned CORE_CLK_KHZ = 40000;

  // Control register bit positions.
  localparam int unsigned WE_BIT    = 0;
  localparam int unsigned EE_BIT    = 1;
  localparam int unsigned BUSY_BIT  = 2;
  localparam int unsigned FAULT_BIT = 3;
  localparam int unsigned VOK_BIT   = 4;
  localparam int unsigned PLEN_LSB  = 5;
  localparam int unsigned BANK_LSB  = 8;
  localparam int unsigned HOLD_BIT  = 15;

  // Flash address bits that name the bank of a location.
  localparam int unsigned ADDR_W        = 18;
  localparam int unsigned ADDR_BANK_LSB = 16;

  // Unlock wait, a least time, rounded up to whole cycles.
  localparam int unsigned UNLOCK_WAIT_NS  = 10000;
  localparam int unsigned UNLOCK_WAIT_CYC =
    (UNLOCK_WAIT_NS * CORE_CLK_KHZ + 999999) / 1000000;
  localparam int unsigned WAIT_W = 9;
  localparam logic [WAIT_W-1:0] WAIT_LOAD =
    WAIT_W'(UNLOCK_WAIT_CYC - 1);

  localparam int unsigned CNT_W = 20;

  // Reset values of the control fields.
  localparam logic       WE_RST   = 1'b0;
  localparam logic       EE_RST   = 1'b0;
  localparam logic [1:0] PLEN_RST = 2'h0;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic       HOLD_RST = 1'b0;

  typedef enum logic [1:0] {
    MODE_STANDARD,
    MODE_ARMED,
    MODE_UNLOCK_WAIT,
    MODE_WRITING
  } flbec_mode_e;

  typedef struct packed {
    logic              ctl_wr;
    logic [15:0]       ctl_wdata;
    logic              mem_wr;
    logic [ADDR_W-1:0] mem_addr;
    logic [15:0]       mem_wdata;
  } flbec_cpu_s;

  typedef struct packed {
    logic       hold;
    logic [1:0] bank;
    logic [1:0] plen;
    logic       ee;
    logic       we;
  } flbec_ctl_s;

endpackage : flbec_pkg

// [rtl/flbec_pulse_tmr.sv]
// Erase pulse timer that counts core clock cycles.
`timescale 1ns/1ps
`default_nettype none
module flbec_pulse_tmr (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       start,
  input  wire logic                       abort,
  input  wire logic [flbec_pkg::CNT_W-1:0] len,
  output logic                            busy,
  output logic                            done
);
  import flbec_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             busy_q;
  logic             busy_d;
  logic             done_q;
  logic             done_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort) begin
      busy_d = 1'b0;
      cnt_d  = '0;
    end else if (start && !busy_q) begin
      busy_d = 1'b1;
      cnt_d  = len;
    end else if (busy_q) begin
      cnt_d = cnt_q - CNT_W'(1);
      if (cnt_q == CNT_W'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : flbec_pulse_tmr
`default_nettype wire

// [rtl/flbec_ctrl.sv]
// Flash bank erase control: unlock, control register and erase sequencing.
`timescale 1ns/1ps
`default_nettype none
module flbec_ctrl #(
  parameter int unsigned PULSE_CYC_0 = 128,
  parameter int unsigned PULSE_CYC_1 = 2048,
  parameter int unsigned PULSE_CYC_2 = 32768,
  parameter int unsigned PULSE_CYC_3 = 524288
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire flbec_pkg::flbec_cpu_s cpu,
  input  wire logic                  vpp_ok_pin,
  output logic [15:0]                ctl_rdata,
  output logic                       writing_mode,
  output logic                       erase_active,
  output logic [1:0]                 erase_bank,
  output logic                       erase_verify_mode,
  output logic                       non_verify_mode
);
  import flbec_pkg::*;

  flbec_mode_e       mode_q;
  flbec_mode_e       mode_d;
  flbec_ctl_s        ctl_q;
  flbec_ctl_s        ctl_d;
  logic [WAIT_W-1:0] wait_q;
  logic [WAIT_W-1:0] wait_d;
  logic              verify_q;
  logic              verify_d;
  logic              fault_q;
  logic              fault_d;
  logic [15:0]       rdata_q;
  logic [15:0]       rdata_d;
  logic              vpp_meta_q;
  logic              vpp_q;
  logic              start;
  logic              abort;
  logic              busy;
  logic              done;
  logic [CNT_W-1:0]  len;

  // The supply comparator is asynchronous to the core clock.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vpp_meta_q <= 1'b0;
      vpp_q      <= 1'b0;
    end else begin
      vpp_meta_q <= vpp_ok_pin;
      vpp_q      <= vpp_meta_q;
    end
  end

  always_comb begin
    case (ctl_q.plen)
      2'h0:    len = CNT_W'(PULSE_CYC_0);
      2'h1:    len = CNT_W'(PULSE_CYC_1);
      2'h2:    len = CNT_W'(PULSE_CYC_2);
      default: len = CNT_W'(PULSE_CYC_3);
    endcase
  end

  always_comb begin
    mode_d   = mode_q;
    ctl_d    = ctl_q;
    wait_d   = wait_q;
    verify_d = verify_q;
    fault_d  = fault_q;
    start    = 1'b0;
    abort    = 1'b0;
    case (mode_q)
      MODE_STANDARD: begin
        if (cpu.ctl_wr) begin
          mode_d = MODE_ARMED;
        end
      end
      MODE_ARMED: begin
        if (cpu.mem_wr) begin
          if (cpu.mem_addr[15:0] == cpu.mem_wdata) begin
            mode_d = MODE_UNLOCK_WAIT;
            wait_d = WAIT_LOAD;
          end else begin
            mode_d = MODE_STANDARD;
          end
        end
      end
      MODE_UNLOCK_WAIT: begin
        // Control writes are locked out until the wait is over.
        if (wait_q == '0) begin
          mode_d = MODE_WRITING;
        end else begin
          wait_d = wait_q - WAIT_W'(1);
        end
      end
      MODE_WRITING: begin
        if (cpu.ctl_wr) begin
          ctl_d.we = cpu.ctl_wdata[WE_BIT];
          ctl_d.hold = cpu.ctl_wdata[HOLD_BIT];
          // Pulse shape and bank stay frozen while a pulse runs.
          if (!busy) begin
            ctl_d.ee   = cpu.ctl_wdata[EE_BIT];
            ctl_d.plen = cpu.ctl_wdata[PLEN_LSB +: 2];
            ctl_d.bank = cpu.ctl_wdata[BANK_LSB +: 2];
          end
          if (!cpu.ctl_wdata[WE_BIT]) begin
            verify_d = 1'b0;
            abort    = busy;
          end
          if (!cpu.ctl_wdata[HOLD_BIT] && !busy) begin
            mode_d = MODE_STANDARD;
            ctl_d  = '{HOLD_RST, BANK_RST, PLEN_RST, EE_RST, WE_RST};
          end
        end else if (cpu.mem_wr && ctl_q.we && ctl_q.ee && !busy &&
                     cpu.mem_addr[ADDR_BANK_LSB +: 2] == ctl_q.bank) begin
          start    = 1'b1;
          verify_d = 1'b0;
          fault_d  = 1'b0;
        end
        if (done) begin
          verify_d = 1'b1;
        end
      end
      default: begin
        mode_d = MODE_STANDARD;
      end
    endcase
    // Placed last so that a supply drop in the clearing cycle still counts.
    if ((busy || start) && !vpp_q) begin
      fault_d = 1'b1;
    end
    // Status positions are never loaded from write data.
    rdata_d           = '0;
    rdata_d[WE_BIT]   = ctl_q.we;
    rdata_d[EE_BIT]   = ctl_q.ee;
    rdata_d[BUSY_BIT] = busy;
    rdata_d[FAULT_BIT] = fault_q;
    rdata_d[VOK_BIT]  = vpp_q;
    rdata_d[PLEN_LSB +: 2] = ctl_q.plen;
    rdata_d[BANK_LSB +: 2] = ctl_q.bank;
    rdata_d[HOLD_BIT] = ctl_q.hold;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q   <= MODE_STANDARD;
      ctl_q    <= '{HOLD_RST, BANK_RST, PLEN_RST, EE_RST, WE_RST};
      wait_q   <= '0;
      verify_q <= 1'b0;
      fault_q  <= 1'b0;
      rdata_q  <= '0;
    end else begin
      mode_q   <= mode_d;
      ctl_q    <= ctl_d;
      wait_q   <= wait_d;
      verify_q <= verify_d;
      fault_q  <= fault_d;
      rdata_q  <= rdata_d;
    end
  end

  flbec_pulse_tmr u_tmr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (start),
    .abort    (abort),
    .len      (len),
    .busy     (busy),
    .done     (done)
  );

  assign ctl_rdata         = rdata_q;
  assign writing_mode      = (mode_q == MODE_WRITING);
  assign erase_active      = busy;
  assign erase_bank        = ctl_q.bank;
  assign erase_verify_mode = verify_q;
  assign non_verify_mode   = writing_mode && !ctl_q.we;

  unlock_gate_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    start |-> $past(mode_q == MODE_WRITING) || mode_q == MODE_WRITING)
    else $error("Erase started outside writing mode.");
  unlock_wait_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    mode_q == MODE_ARMED && mode_d == MODE_UNLOCK_WAIT |=>
    (mode_q == MODE_UNLOCK_WAIT)[*8])
    else $error("Unlock wait ended too early.");
  config_nostart_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    cpu.ctl_wr |-> !start)
    else $error("Control write started a pulse.");
  we_gate_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    start |-> ctl_q.we && ctl_q.ee)
    else $error("Erase started without enable and select.");
  bank_match_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    start |-> cpu.mem_addr[ADDR_BANK_LSB +: 2] == ctl_q.bank)
    else $error("Erase started outside the selected bank.");
  // An abort clears write-enable at the same edge that drops busy.
  busy_len_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    start |=> (erase_active || !ctl_q.we)[*8])
    else $error("Busy dropped early.");
  verify_entry_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    done && !cpu.ctl_wr |=> erase_verify_mode)
    else $error("Verify mode not entered after pulse.");
  fault_set_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    erase_active && !vpp_q |=> fault_q)
    else $error("Supply fault not flagged.");
  vok_mirror_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    1'b1 |=> ctl_rdata[VOK_BIT] == $past(vpp_q))
    else $error("Voltage-ok bit wrong.");
  // A pulse that ends in the same cycle still wins verify mode.
  nonverify_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    writing_mode && cpu.ctl_wr && !cpu.ctl_wdata[WE_BIT] && !done |=>
    !erase_verify_mode && !erase_active)
    else $error("Clearing enable left verify or pulse on.");
  hold_keep_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    writing_mode && ctl_q.hold && !cpu.ctl_wr |=> writing_mode)
    else $error("Writing mode left while hold set.");

endmodule : flbec_ctrl
`default_nettype wire

// [dv/flbec_ctrl_tb.sv]
// Self-checking testbench for the flash bank erase control.
`timescale 1ns/1ps
`default_nettype none
module flbec_ctrl_tb;
  import flbec_pkg::*;

  // Short pulse lengths keep the run brief.
  localparam int unsigned CYC [4] = '{16, 20, 24, 32};
  localparam int unsigned CEIL    = 3000;
  // Two verify reads stand 4 us apart, which is 160 cycles at 40 MHz.
  localparam int unsigned VERIFY_GAP = 160;

  logic        core_clk;
  logic        rstn;
  logic        vpp_ok_pin;
  flbec_cpu_s  cpu;
  logic [15:0] ctl_rdata;
  logic        writing_mode;
  logic        erase_active;
  logic [1:0]  erase_bank;
  logic        erase_verify_mode;
  logic        non_verify_mode;
  int          failures;
  int          num_checks;
  int          cycles = 0;
  logic        last_drop;

  flbec_ctrl #(
    .PULSE_CYC_0(CYC[0]),
    .PULSE_CYC_1(CYC[1]),
    .PULSE_CYC_2(CYC[2]),
    .PULSE_CYC_3(CYC[3])
  ) DUT (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .cpu               (cpu),
    .vpp_ok_pin        (vpp_ok_pin),
    .ctl_rdata         (ctl_rdata),
    .writing_mode      (writing_mode),
    .erase_active      (erase_active),
    .erase_bank        (erase_bank),
    .erase_verify_mode (erase_verify_mode),
    .non_verify_mode   (non_verify_mode)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // A hang is cut short here and still ends in the one closing report.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      failures = failures + 1;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic chk(input logic [15:0] got, exp, input string what);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Strobes are one cycle wide, raised and dropped at falling edges.
  task automatic ctl_write(input logic [15:0] d);
    cpu.ctl_wr    = 1'b1;
    cpu.ctl_wdata = d;
    tick(1);
    cpu.ctl_wr    = 1'b0;
  endtask : ctl_write

  task automatic mem_write(input logic [17:0] a, input logic [15:0] d);
    cpu.mem_wr    = 1'b1;
    cpu.mem_addr  = a;
    cpu.mem_wdata = d;
    tick(1);
    cpu.mem_wr    = 1'b0;
  endtask : mem_write

  task automatic erase(input logic [1:0] bank, plen, input logic drop);
    logic [15:0] cfg;
    int          cnt;
    cfg = 16'h8003 | (16'(plen) << 5) | (16'(bank) << 8);
    ctl_write(cfg | 16'h000c);
    tick(2);
    // A fault flag left by the last pulse stands until the next start.
    chk(ctl_rdata, cfg | 16'h0010 | {12'h0, last_drop, 3'h0},
        "config");
    chk(16'(erase_active), 16'h0, "pulse on config");
    mem_write({2'(bank + 2'h1), 16'h0040}, 16'h0040);
    tick(2);
    chk(16'(erase_active), 16'h0, "other bank");
    mem_write({bank, 16'h0100}, 16'h0100);
    tick(1);
    chk(16'(erase_active), 16'h1, "start");
    chk(16'(erase_bank), 16'(bank), "bank");
    // The cycle already waited above belongs to the pulse as well.
    cnt = 1;
    while (erase_active === 1'b1 && cnt < 100) begin
      cnt = cnt + 1;
      tick(1);
      if (cnt == 2) chk(16'(ctl_rdata[2]), 16'h1, "busy");
      if (drop && cnt == 5) vpp_ok_pin = 1'b0;
      if (drop && cnt == 10) begin
        chk(16'(ctl_rdata[4]), 16'h0, "supply low");
        vpp_ok_pin = 1'b1;
      end
    end
    chk(16'(cnt), 16'(CYC[plen]), "pulse length");
    tick(1);
    chk(16'(erase_verify_mode), 16'h1, "verify mode");
    chk(ctl_rdata, cfg | 16'h0010 | {12'h0, drop, 3'h0}, "after");
    tick(VERIFY_GAP);
    chk(16'(erase_verify_mode), 16'h1, "verify holds");
    last_drop = drop;
  endtask : erase

  initial begin
    rstn       = 1'b0;
    vpp_ok_pin = 1'b1;
    cpu        = '0;
    failures   = 0;
    num_checks = 0;
    last_drop  = 1'b0;
    tick(3);
    rstn = 1'b1;
    tick(4);
    chk(ctl_rdata, 16'h0010, "reset image");
    ctl_write(16'h8003);
    tick(2);
    chk(ctl_rdata, 16'h0010, "locked fields");
    mem_write(18'h01234, 16'h1234);
    tick(399);
    chk(16'(writing_mode), 16'h0, "unlock wait");
    tick(2);
    chk(16'(writing_mode), 16'h1, "writing mode");
    // Each bank is taken as already programmed to zeros and erased once.
    for (int i = 0; i < 4; i++) begin
      erase(2'(i), 2'(i), i == 1);
    end
    ctl_write(16'h8263);
    tick(1);
    mem_write(18'h20000, 16'h0000);
    tick(3);
    ctl_write(16'h8262);
    tick(1);
    chk(16'(erase_active), 16'h0, "abort");
    chk(16'(erase_verify_mode), 16'h0, "no verify");
    chk(16'(non_verify_mode), 16'h1, "non-verify");
    mem_write(18'h20000, 16'h0000);
    tick(2);
    chk(16'(erase_active), 16'h0, "disabled");
    ctl_write(16'h0000);
    tick(2);
    chk(16'(writing_mode), 16'h0, "standard");
    chk(ctl_rdata, 16'h0010, "fields reset");
    ctl_write(16'h0000);
    mem_write(18'h00010, 16'h0011);
    tick(405);
    chk(16'(writing_mode), 16'h0, "bad unlock");
    summarize();
  end

endmodule : flbec_ctrl_tb
`default_nettype wire
